/* File: core/ccfb_bank.v */
// Processor control and debug flag bank with a plain register port.
// Assumes one 20 MHz clock and inputs synchronous to it.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "ccfb_consts.vh"

module ccfb_bank (
   // Clock and reset
   input wire CLK,
   input wire RESET_N,
   // Register port
   input wire [4:0] ADDR,
   input wire [31:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [31:0] RDATA,
   output reg UD_FAULT,
   // Execution events
   input wire [1:0] CPL,
   input wire PMC_REQ,
   input wire TSC_REQ,
   output reg PMC_GRANT,
   output reg PMC_REFUSE,
   output reg TSC_GRANT,
   output reg TSC_REFUSE,
   input wire TASK_SWITCH,
   output reg TLB_FLUSH,
   output reg TLB_KEEP_GLOBAL,
   input wire HW_ERROR,
   output reg MC_EXCEPTION,
   input wire FP_ERROR,
   output reg FP_FAULT_REPORT,
   input wire ALIGNMENT_CHECK_FLAG,
   output reg ALIGN_CHECK_ON,
   input wire DESC_LOAD,
   input wire DESC_ACCESSED,
   output reg LOCKED_RMW,
   // Bus cycle and external cache pins
   input wire NONPAGED_CYCLE,
   output reg EXT_CACHE_OFF_PIN_N,
   output reg EXT_WRITETHROUGH_PIN_N,
   // Mode levels
   output reg WIDE_PHYS_ADDRESS,
   output reg PAGE_4M_OK,
   output reg PAGE_2M_OK,
   output reg V86_IRQ_EXTENSIONS,
   output reg PROT_MODE_VIRTUAL_IRQ,
   output reg OS_SIMD_FAULT_SUPPORT,
   output reg OS_STATE_SAVE_SUPPORT,
   output reg WRITE_PROTECT_ON,
   output reg CACHE_ENABLE,
   output reg WRITE_THROUGH_ON,
   output reg INVAL_CYCLES_ON,
   // Breakpoints
   input wire [3:0] BP_HIT,
   output reg [3:0] BP_ON_EXEC,
   output reg [3:0] BP_ON_WRITE,
   output reg [3:0] BP_ON_RW,
   output reg [3:0] BP_ON_IO,
   output reg [3:0] BP_UNDEFINED
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [31:0] sysctl_r;
   reg [31:0] pagebase_r;
   reg [31:0] extctl_r;
   reg [31:0] dstat_r;
   reg [31:0] bpctl_r;
   reg [31:0] dstat_nxt;
   reg [31:0] rd_nxt;
   wire dbg_ext;
   wire alias_hit;
   wire wr_sys;
   wire wr_pb;
   wire wr_ext;
   wire wr_ds;
   wire wr_bp;
   wire flush_evt;
   wire pmc_ok;
   wire tsc_ok;
   wire pins_live;
   reg [31:0] rdata_nxt;
   reg ud_fault_nxt;
   reg pmc_grant_nxt;
   reg pmc_refuse_nxt;
   reg tsc_grant_nxt;
   reg tsc_refuse_nxt;
   reg tlb_flush_nxt;
   reg tlb_keep_global_nxt;
   reg mc_exception_nxt;
   reg fp_fault_report_nxt;
   reg locked_rmw_nxt;
   reg ext_cache_off_pin_n_nxt;
   reg ext_writethrough_pin_n_nxt;
   reg wide_phys_address_nxt;
   reg page_4m_ok_nxt;
   reg page_2m_ok_nxt;
   reg v86_irq_extensions_nxt;
   reg prot_mode_virtual_irq_nxt;
   reg os_simd_fault_support_nxt;
   reg os_state_save_support_nxt;
   reg write_protect_on_nxt;
   reg cache_enable_nxt;
   reg write_through_on_nxt;
   reg inval_cycles_on_nxt;
   reg align_check_on_nxt;

   assign dbg_ext = extctl_r[`CCFB_EXT_DBG];
   assign alias_hit = (ADDR == `CCFB_OFS_ALIAS_A) || (ADDR == `CCFB_OFS_ALIAS_B);
   assign wr_sys = WR && (ADDR == `CCFB_OFS_SYSCTL);
   assign wr_pb = WR && (ADDR == `CCFB_OFS_PAGEBASE);
   assign wr_ext = WR && (ADDR == `CCFB_OFS_EXTCTL);
   assign wr_ds = WR && ((ADDR == `CCFB_OFS_DSTAT) ||
      (!dbg_ext && ADDR == `CCFB_OFS_ALIAS_A));
   assign wr_bp = WR && ((ADDR == `CCFB_OFS_BPCTL) ||
      (!dbg_ext && ADDR == `CCFB_OFS_ALIAS_B));
   assign flush_evt = TASK_SWITCH || wr_pb;
   assign pmc_ok = extctl_r[`CCFB_EXT_PMC] || (CPL == 2'h0);
   assign tsc_ok = !extctl_r[`CCFB_EXT_TSD] || (CPL == 2'h0);
   assign pins_live = sysctl_r[`CCFB_SYS_PG] && NONPAGED_CYCLE;

   // ----------------------------------------
   // Debug status next value
   // ----------------------------------------
   always @* begin
      dstat_nxt = dstat_r;
      if (wr_ds) begin
         dstat_nxt = WDATA & `CCFB_DS_MASK;
      end
      dstat_nxt[3:0] = dstat_nxt[3:0] | BP_HIT;
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always @* begin
      rd_nxt = 32'h00000000;
      case (ADDR)
         `CCFB_OFS_SYSCTL: begin
            rd_nxt = sysctl_r;
         end
         `CCFB_OFS_PAGEBASE: begin
            rd_nxt = pagebase_r;
         end
         `CCFB_OFS_EXTCTL: begin
            rd_nxt = extctl_r;
         end
         `CCFB_OFS_DSTAT: begin
            rd_nxt = dstat_r;
         end
         `CCFB_OFS_BPCTL: begin
            rd_nxt = bpctl_r;
         end
         `CCFB_OFS_ALIAS_A: begin
            rd_nxt = dbg_ext ? 32'h00000000 : dstat_r;
         end
         `CCFB_OFS_ALIAS_B: begin
            rd_nxt = dbg_ext ? 32'h00000000 : bpctl_r;
         end
         default: begin
            rd_nxt = 32'h00000000;
         end
      endcase
   end

   // ----------------------------------------
   // Register port answer
   // ----------------------------------------
   always @* begin
      rdata_nxt = 32'h00000000;
      ud_fault_nxt = 1'h0;
      if (RD) begin
         rdata_nxt = rd_nxt;
      end
      if ((RD || WR) && alias_hit && dbg_ext) begin
         ud_fault_nxt = 1'h1;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sysctl_r <= `CCFB_SYS_RST;
         pagebase_r <= `CCFB_PB_RST;
         extctl_r <= `CCFB_EXT_RST;
         dstat_r <= `CCFB_DS_RST;
         bpctl_r <= `CCFB_BP_RST;
         RDATA <= 32'h00000000;
         UD_FAULT <= 1'b0;
      end else begin
         if (wr_sys) begin
            sysctl_r <= WDATA;
         end
         if (wr_pb) begin
            pagebase_r <= WDATA;
         end
         if (wr_ext) begin
            extctl_r <= WDATA & `CCFB_EXT_MASK;
         end
         dstat_r <= dstat_nxt;
         if (wr_bp) begin
            bpctl_r <= WDATA & `CCFB_BP_CTL_MASK;
         end
         RDATA <= rdata_nxt;
         UD_FAULT <= ud_fault_nxt;
      end
   end

   // ----------------------------------------
   // Event responses, next values
   // ----------------------------------------
   always @* begin
      pmc_grant_nxt = PMC_REQ && pmc_ok;
      pmc_refuse_nxt = PMC_REQ && !pmc_ok;
      tsc_grant_nxt = TSC_REQ && tsc_ok;
      tsc_refuse_nxt = TSC_REQ && !tsc_ok;
      tlb_flush_nxt = flush_evt;
      tlb_keep_global_nxt = flush_evt && extctl_r[`CCFB_EXT_GPG];
      mc_exception_nxt = HW_ERROR && extctl_r[`CCFB_EXT_HWE];
      fp_fault_report_nxt = FP_ERROR && sysctl_r[`CCFB_SYS_NE];
      locked_rmw_nxt = DESC_LOAD && !DESC_ACCESSED;
   end

   // ----------------------------------------
   // Privilege checks and event responses
   // ----------------------------------------
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PMC_GRANT <= 1'b0;
         PMC_REFUSE <= 1'b0;
         TSC_GRANT <= 1'b0;
         TSC_REFUSE <= 1'b0;
         TLB_FLUSH <= 1'b0;
         TLB_KEEP_GLOBAL <= 1'b0;
         MC_EXCEPTION <= 1'b0;
         FP_FAULT_REPORT <= 1'b0;
         LOCKED_RMW <= 1'b0;
      end else begin
         PMC_GRANT <= pmc_grant_nxt;
         PMC_REFUSE <= pmc_refuse_nxt;
         TSC_GRANT <= tsc_grant_nxt;
         TSC_REFUSE <= tsc_refuse_nxt;
         TLB_FLUSH <= tlb_flush_nxt;
         TLB_KEEP_GLOBAL <= tlb_keep_global_nxt;
         MC_EXCEPTION <= mc_exception_nxt;
         FP_FAULT_REPORT <= fp_fault_report_nxt;
         LOCKED_RMW <= locked_rmw_nxt;
      end
   end

   // ----------------------------------------
   // Mode levels and external pins, next values
   // ----------------------------------------
   always @* begin
      ext_cache_off_pin_n_nxt = 1'h1;
      ext_writethrough_pin_n_nxt = 1'h1;
      if (pins_live) begin
         ext_cache_off_pin_n_nxt = !pagebase_r[`CCFB_PB_PCD];
         ext_writethrough_pin_n_nxt = !pagebase_r[`CCFB_PB_PWT];
      end
      wide_phys_address_nxt = extctl_r[`CCFB_EXT_WPA];
      page_4m_ok_nxt = extctl_r[`CCFB_EXT_LPG] && !extctl_r[`CCFB_EXT_WPA];
      page_2m_ok_nxt = extctl_r[`CCFB_EXT_LPG] && extctl_r[`CCFB_EXT_WPA];
      v86_irq_extensions_nxt = extctl_r[`CCFB_EXT_V86];
      prot_mode_virtual_irq_nxt = extctl_r[`CCFB_EXT_PVI];
      os_simd_fault_support_nxt = extctl_r[`CCFB_EXT_OSF];
      os_state_save_support_nxt = extctl_r[`CCFB_EXT_OSS];
      write_protect_on_nxt = sysctl_r[`CCFB_SYS_WP];
      cache_enable_nxt = !sysctl_r[`CCFB_SYS_CD];
      write_through_on_nxt = !sysctl_r[`CCFB_SYS_NW];
      inval_cycles_on_nxt = !sysctl_r[`CCFB_SYS_NW];
      align_check_on_nxt = sysctl_r[`CCFB_SYS_AM] && ALIGNMENT_CHECK_FLAG;
   end

   // ----------------------------------------
   // Mode levels and external pins
   // ----------------------------------------
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         EXT_CACHE_OFF_PIN_N <= 1'b1;
         EXT_WRITETHROUGH_PIN_N <= 1'b1;
         WIDE_PHYS_ADDRESS <= 1'b0;
         PAGE_4M_OK <= 1'b0;
         PAGE_2M_OK <= 1'b0;
         V86_IRQ_EXTENSIONS <= 1'b0;
         PROT_MODE_VIRTUAL_IRQ <= 1'b0;
         OS_SIMD_FAULT_SUPPORT <= 1'b0;
         OS_STATE_SAVE_SUPPORT <= 1'b0;
         WRITE_PROTECT_ON <= 1'b0;
         CACHE_ENABLE <= 1'b0;
         WRITE_THROUGH_ON <= 1'b0;
         INVAL_CYCLES_ON <= 1'b0;
         ALIGN_CHECK_ON <= 1'b0;
      end else begin
         EXT_CACHE_OFF_PIN_N <= ext_cache_off_pin_n_nxt;
         EXT_WRITETHROUGH_PIN_N <= ext_writethrough_pin_n_nxt;
         WIDE_PHYS_ADDRESS <= wide_phys_address_nxt;
         PAGE_4M_OK <= page_4m_ok_nxt;
         PAGE_2M_OK <= page_2m_ok_nxt;
         V86_IRQ_EXTENSIONS <= v86_irq_extensions_nxt;
         PROT_MODE_VIRTUAL_IRQ <= prot_mode_virtual_irq_nxt;
         OS_SIMD_FAULT_SUPPORT <= os_simd_fault_support_nxt;
         OS_STATE_SAVE_SUPPORT <= os_state_save_support_nxt;
         WRITE_PROTECT_ON <= write_protect_on_nxt;
         CACHE_ENABLE <= cache_enable_nxt;
         WRITE_THROUGH_ON <= write_through_on_nxt;
         INVAL_CYCLES_ON <= inval_cycles_on_nxt;
         ALIGN_CHECK_ON <= align_check_on_nxt;
      end
   end

   // ----------------------------------------
   // Breakpoint type decode
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_bp
         wire [1:0] bt;
         wire exec_nxt;
         wire write_nxt;
         wire rw_nxt;
         wire io_nxt;
         wire undef_nxt;
         assign bt = bpctl_r[`CCFB_BP_TYPE_LSB + 4 * gi + 1:`CCFB_BP_TYPE_LSB + 4 * gi];
         assign exec_nxt = (bt == `CCFB_BT_EXEC);
         assign write_nxt = (bt == `CCFB_BT_WR);
         assign rw_nxt = (bt == `CCFB_BT_RW);
         assign io_nxt = (bt == `CCFB_BT_IO) && dbg_ext;
         assign undef_nxt = (bt == `CCFB_BT_IO) && !dbg_ext;
         always @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               BP_ON_EXEC[gi] <= 1'b0;
               BP_ON_WRITE[gi] <= 1'b0;
               BP_ON_RW[gi] <= 1'b0;
               BP_ON_IO[gi] <= 1'b0;
               BP_UNDEFINED[gi] <= 1'b0;
            end else begin
               BP_ON_EXEC[gi] <= exec_nxt;
               BP_ON_WRITE[gi] <= write_nxt;
               BP_ON_RW[gi] <= rw_nxt;
               BP_ON_IO[gi] <= io_nxt;
               BP_UNDEFINED[gi] <= undef_nxt;
            end
         end
      end
   endgenerate

endmodule

/* File: core/ccfb_consts.vh */
// Constants for the control flag bank: offsets, field positions, masks.
// Assumes inclusion by bare name from the bank module.
`ifndef CCFB_CONSTS_VH
`define CCFB_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCFB_OFS_SYSCTL 5'h00
`define CCFB_OFS_PAGEBASE 5'h03
`define CCFB_OFS_EXTCTL 5'h04
`define CCFB_OFS_ALIAS_A 5'h14
`define CCFB_OFS_ALIAS_B 5'h15
`define CCFB_OFS_DSTAT 5'h16
`define CCFB_OFS_BPCTL 5'h17
// ----------------------------------------
// Extension control fields
// ----------------------------------------
`define CCFB_EXT_V86 0
`define CCFB_EXT_PVI 1
`define CCFB_EXT_TSD 2
`define CCFB_EXT_DBG 3
`define CCFB_EXT_LPG 4
`define CCFB_EXT_WPA 5
`define CCFB_EXT_HWE 6
`define CCFB_EXT_GPG 7
`define CCFB_EXT_PMC 8
`define CCFB_EXT_OSS 9
`define CCFB_EXT_OSF 10
`define CCFB_EXT_MASK 32'h000007FF
`define CCFB_EXT_RST 32'h00000000
// ----------------------------------------
// System control and page base fields
// ----------------------------------------
`define CCFB_SYS_NE 5
`define CCFB_SYS_WP 16
`define CCFB_SYS_AM 18
`define CCFB_SYS_NW 29
`define CCFB_SYS_CD 30
`define CCFB_SYS_PG 31
`define CCFB_SYS_RST 32'h00000000
`define CCFB_PB_PWT 3
`define CCFB_PB_PCD 4
`define CCFB_PB_RST 32'h00000000
// ----------------------------------------
// Debug fields
// ----------------------------------------
`define CCFB_BP_TYPE_LSB 16
`define CCFB_BP_CTL_MASK 32'hFFFF27FF
`define CCFB_BP_RST 32'h00000000
`define CCFB_DS_MASK 32'hFFFFEFFF
`define CCFB_DS_RST 32'h00000000
`define CCFB_BT_EXEC 2'h0
`define CCFB_BT_WR 2'h1
`define CCFB_BT_IO 2'h2
`define CCFB_BT_RW 2'h3
`endif

/* File: sim/ccfb_bank_assertions.sv */
// Checker for the control flag bank, bound to its top module.
// Assumes one clock domain and the bank's register index map.
`timescale 1ns/1ps
module ccfb_bank_assertions (
   // Clock and reset
   input wire CLK,
   input wire RESET_N,
   // Register port
   input wire [4:0] ADDR,
   input wire WR,
   input wire RD,
   input wire [31:0] RDATA,
   input wire UD_FAULT,
   // Events and levels
   input wire PMC_REQ,
   input wire PMC_GRANT,
   input wire PMC_REFUSE,
   input wire TASK_SWITCH,
   input wire TLB_FLUSH,
   input wire DESC_LOAD,
   input wire DESC_ACCESSED,
   input wire LOCKED_RMW,
   input wire NONPAGED_CYCLE,
   input wire EXT_CACHE_OFF_PIN_N,
   input wire WIDE_PHYS_ADDRESS,
   input wire PAGE_4M_OK,
   input wire PAGE_2M_OK
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   pmc_answer_a: assert property (PMC_REQ |=> PMC_GRANT != PMC_REFUSE)
      else $error("counter read without a single answer");
   ud_cause_a: assert property (UD_FAULT |-> $past((WR || RD) && ADDR[4:1] == 4'hA)
      && RDATA == 32'h0) else $error("fault without alias access");
   bp_reserved_a: assert property ($past(RD && ADDR == 5'h17) |->
      (RDATA & 32'h0000D800) == 32'h0) else $error("control reserved bit set");
   ds_fixed_a: assert property ($past(RD && ADDR == 5'h16) |-> !RDATA[12])
      else $error("status bit 12 set");
   flush_cause_a: assert property ((TASK_SWITCH || (WR && ADDR == 5'h03)) |=> TLB_FLUSH)
      else $error("flush missing");
   page_size_a: assert property (PAGE_2M_OK |-> WIDE_PHYS_ADDRESS && !PAGE_4M_OK)
      else $error("page size mix");
   pin_drive_a: assert property (!EXT_CACHE_OFF_PIN_N |-> $past(NONPAGED_CYCLE))
      else $error("pin driven outside cycle");
   desc_rmw_a: assert property (DESC_LOAD |=> LOCKED_RMW == !$past(DESC_ACCESSED))
      else $error("locked update wrong");
   cover property (UD_FAULT);
   cover property (LOCKED_RMW);
   cover property (PAGE_2M_OK);
endmodule
bind ccfb_bank ccfb_bank_assertions ccfb_bank_assertions_i (.CLK(CLK), .RESET_N(RESET_N),
   .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .UD_FAULT(UD_FAULT), .PMC_REQ(PMC_REQ),
   .PMC_GRANT(PMC_GRANT), .PMC_REFUSE(PMC_REFUSE), .TASK_SWITCH(TASK_SWITCH),
   .TLB_FLUSH(TLB_FLUSH), .DESC_LOAD(DESC_LOAD), .DESC_ACCESSED(DESC_ACCESSED),
   .LOCKED_RMW(LOCKED_RMW), .NONPAGED_CYCLE(NONPAGED_CYCLE),
   .EXT_CACHE_OFF_PIN_N(EXT_CACHE_OFF_PIN_N), .WIDE_PHYS_ADDRESS(WIDE_PHYS_ADDRESS),
   .PAGE_4M_OK(PAGE_4M_OK), .PAGE_2M_OK(PAGE_2M_OK));

/* File: sim/cpu_control_flag_bank_test.sv */
// Self-checking bench for the control flag bank.
// Assumes the bank is compiled alongside with its constants header.
`timescale 1ns/1ps
`define CHK(n,e,s) begin compares++; if ((s) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module cpu_control_flag_bank_test;
   typedef struct packed {
      logic [4:0] a;
      logic [31:0] d;
      logic [31:0] r;
      logic [1:0] c;
      logic k;
      logic [9:0] e;
      logic [8:0] x;
   } ccfb_row_t;
   ccfb_row_t rows [0:10];
   logic clk, reset_n, wr, rd, acc, alf, npc;
   logic [4:0] addr;
   logic [31:0] wdata, rd_v;
   logic [1:0] cpl;
   logic [9:0] ev;
   wire [31:0] rdata;
   wire [8:0] evo;
   wire [6:0] elv;
   wire [4:0] slv;
   wire [1:0] pins;
   wire [19:0] bpv;
   wire ud;
   int i, compares = 0, err_total = 0, cycles = 0;
   ccfb_bank ccfb_bank_i (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .UD_FAULT(ud), .CPL(cpl), .PMC_REQ(ev[9]),
      .TSC_REQ(ev[8]), .PMC_GRANT(evo[8]), .PMC_REFUSE(evo[7]), .TSC_GRANT(evo[6]),
      .TSC_REFUSE(evo[5]), .TASK_SWITCH(ev[7]), .TLB_FLUSH(evo[4]),
      .TLB_KEEP_GLOBAL(evo[3]), .HW_ERROR(ev[6]), .MC_EXCEPTION(evo[2]),
      .FP_ERROR(ev[5]), .FP_FAULT_REPORT(evo[1]), .ALIGNMENT_CHECK_FLAG(alf),
      .ALIGN_CHECK_ON(slv[0]), .DESC_LOAD(ev[4]), .DESC_ACCESSED(acc),
      .LOCKED_RMW(evo[0]), .NONPAGED_CYCLE(npc), .EXT_CACHE_OFF_PIN_N(pins[1]),
      .EXT_WRITETHROUGH_PIN_N(pins[0]), .WIDE_PHYS_ADDRESS(elv[6]),
      .PAGE_4M_OK(elv[5]), .PAGE_2M_OK(elv[4]), .V86_IRQ_EXTENSIONS(elv[3]),
      .PROT_MODE_VIRTUAL_IRQ(elv[2]), .OS_SIMD_FAULT_SUPPORT(elv[1]),
      .OS_STATE_SAVE_SUPPORT(elv[0]), .WRITE_PROTECT_ON(slv[4]), .CACHE_ENABLE(slv[3]),
      .WRITE_THROUGH_ON(slv[2]), .INVAL_CYCLES_ON(slv[1]), .BP_HIT(ev[3:0]),
      .BP_ON_EXEC(bpv[19:16]), .BP_ON_WRITE(bpv[15:12]), .BP_ON_RW(bpv[11:8]),
      .BP_ON_IO(bpv[7:4]), .BP_UNDEFINED(bpv[3:0]));
   // ----------------------------------------
   // Bus and event tasks
   // ----------------------------------------
   task wrr(input [4:0] a, input [31:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask
   task rdr(input [4:0] a);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 rd_v = rdata;
   endtask
   task tick;
      @(posedge clk) #1;
   endtask
   task fire(input [9:0] e, input [1:0] c, input k);
      @(posedge clk) begin ev <= e; cpl <= c; acc <= k; end
      @(posedge clk) ev <= 10'h0;
      #1;
   endtask
   task finish_test;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, timeout and sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin err_total++; finish_test; end
   end
   initial begin
      {reset_n, wr, rd, acc, alf, npc} = 6'h0;
      addr = 5'h0; wdata = 32'h0; cpl = 2'h0; ev = 10'h0;
      rows[0] = {5'h04, 32'hFFFFFFFF, 32'h000007FF, 2'h3, 1'b0, 10'h080, 9'h018};
      rows[1] = {5'h00, 32'hFFFFFFFF, 32'hFFFFFFFF, 2'h0, 1'b0, 10'h020, 9'h002};
      rows[2] = {5'h03, 32'hA5A5A5A5, 32'hA5A5A5A5, 2'h0, 1'b0, 10'h040, 9'h004};
      rows[3] = {5'h17, 32'hFFFFFFFF, 32'hFFFF27FF, 2'h3, 1'b0, 10'h200, 9'h100};
      rows[4] = {5'h16, 32'hFFFFFFFF, 32'hFFFFEFFF, 2'h1, 1'b0, 10'h100, 9'h020};
      rows[5] = {5'h14, 32'h00000000, 32'h00000000, 2'h0, 1'b0, 10'h100, 9'h040};
      rows[6] = {5'h1F, 32'hFFFFFFFF, 32'h00000000, 2'h0, 1'b0, 10'h010, 9'h001};
      rows[7] = {5'h04, 32'h00000000, 32'h00000000, 2'h3, 1'b1, 10'h2D0, 9'h090};
      rows[8] = {5'h14, 32'h0000000A, 32'h0000000A, 2'h3, 1'b0, 10'h100, 9'h040};
      rows[9] = {5'h15, 32'h30210000, 32'h30210000, 2'h0, 1'b0, 10'h001, 9'h000};
      rows[10] = {5'h00, 32'h00000000, 32'h00000000, 2'h0, 1'b0, 10'h020, 9'h000};
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      rdr(5'h04);
      `CHK("ext reset", 32'h0, rd_v)
      `CHK("ext levels", 7'h00, elv)
      `CHK("cache pins", 2'h3, pins)
      `CHK("sys levels", 5'h0E, slv)
      for (i = 0; i < 11; i++) begin
         wrr(rows[i].a, rows[i].d);
         rdr(rows[i].a);
         `CHK("readback", rows[i].r, rd_v)
         `CHK("ud fault", (i == 5), ud)
         fire(rows[i].e, rows[i].c, rows[i].k);
         `CHK("events", rows[i].x, evo)
      end
      rdr(5'h16);
      `CHK("alias status", 32'h0000000B, rd_v)
      `CHK("bp types", {4'h4, 4'h1, 4'h8, 4'h0, 4'h2}, bpv)
      wrr(5'h04, 32'h00000413);
      tick;
      `CHK("ext levels", 7'h2E, elv)
      wrr(5'h04, 32'h00000238);
      tick;
      `CHK("ext levels", 7'h51, elv)
      `CHK("bp types", {4'h4, 4'h1, 4'h8, 4'h2, 4'h0}, bpv)
      @(posedge clk) alf <= 1'b1;
      wrr(5'h00, 32'h60050000);
      tick;
      `CHK("sys levels", 5'h11, slv)
      wrr(5'h03, 32'h00000010);
      `CHK("page base flush", 9'h010, evo)
      wrr(5'h00, 32'h80000000);
      @(posedge clk) npc <= 1'b1;
      tick;
      `CHK("cache pins", 2'h1, pins)
      @(posedge clk) npc <= 1'b0;
      tick;
      `CHK("cache pins", 2'h3, pins)
      wrr(5'h15, 32'h00000000);
      `CHK("ud on write", 1'h1, ud)
      rdr(5'h17);
      `CHK("alias refused", 32'h30210000, rd_v)
      @(posedge clk) reset_n <= 1'h0;
      repeat (3) @(posedge clk);
      reset_n <= 1'h1;
      rdr(5'h04);
      `CHK("ext rearm", 32'h0, rd_v)
      `CHK("ext levels", 7'h00, elv)
      `CHK("sys levels", 5'h0E, slv)
      @(posedge clk) begin addr <= 5'h16; wdata <= 32'h0; wr <= 1'h1; ev <= 10'h004; end
      @(posedge clk) begin wr <= 1'h0; ev <= 10'h000; end
      rdr(5'h16);
      `CHK("hit over clear", 32'h00000004, rd_v)
      finish_test;
   end
endmodule
